// ==== logic/sprm_routing.sv ====
// Purpose: Serial port pin routing multiplexers between ports, pads and fabric
// Assumes: Boot code loads every configuration entry before the ports are used
// Notes: Configuration is static; inputs from pads and fabric are synchronised
// Summary of operation
// RULE1 - Multiplexers 4, 5, 12 and 13 share one pad buffer between a serial line and a GPIO.
// RULE2 - Multiplexers 64 to 69 and 77 to 82 link modem lines to fabric signals, not pads.
// RULE3 - Each transmit or receive multiplexer gives the pad to exactly one function at a time.
// RULE4 - Multiplexer 4 on the serial side drives the pad from the port 0 transmit line; the code puts it on pad_out but keeps pad_oe low.
// RULE5 - Multiplexer 45 can route GPIO 20 to fabric signals with index 29.
// RULE6 - Software loads each multiplexer's configuration to reach the fabric route.
// RULE7 - Multiplexer 64 on the fabric route passes port 0 RTS to to-fabric signal 48.
// RULE8 - Port 0 uses fabric signals 48 to 53 and port 1 uses 61 to 66 for modem lines.
// RULE9 - Boot code loads all configuration entries at start-up before the ports are used.
// RULE10 - Outgoing modem lines tie primary enable high; incoming and receive lines tie it low.
// RULE11 - Each multiplexer holds pull-up, pull-down and Schmitt settings with its selection.
`timescale 1ns/1ps
`default_nettype none

module sprm_routing (
    input wire logic core_clk, // System clock, 50 MHz
    input wire logic rstn, // Async reset, active low
    input wire logic cfg_wr, // Configuration write strobe
    input wire logic [sprm_pkg::ENTRY_W-1:0] cfg_entry, // Entry to write or read
    input wire sprm_pkg::sprm_cfg_t cfg_wdata, // Configuration write value
    output sprm_pkg::sprm_cfg_t cfg_rdata, // Configuration of cfg_entry
    output logic [sprm_pkg::MUXNUM_W-1:0] cfg_mux_num, // Multiplexer number of cfg_entry
    output logic cfg_all_loaded, // Every entry written since reset
    input wire logic uart0_txd, // Port 0 transmit line
    output logic uart0_rxd, // Port 0 receive line
    input wire logic uart1_txd, // Port 1 transmit line
    output logic uart1_rxd, // Port 1 receive line
    input wire logic uart0_rts, // Port 0 request to send
    input wire logic uart0_dtr, // Port 0 terminal ready
    output sprm_pkg::sprm_modem_in_t uart0_modem_in, // Port 0 incoming modem lines
    input wire logic uart1_rts, // Port 1 request to send
    input wire logic uart1_dtr, // Port 1 terminal ready
    output sprm_pkg::sprm_modem_in_t uart1_modem_in, // Port 1 incoming modem lines
    input wire logic [sprm_pkg::PAD_COUNT-1:0] gpio_out, // GPIO 20, 21, 28, 29 outputs
    input wire logic [sprm_pkg::PAD_COUNT-1:0] gpio_oe, // GPIO 20, 21, 28, 29 enables
    output logic [sprm_pkg::PAD_COUNT-1:0] gpio_in, // GPIO 20, 21, 28, 29 inputs
    input wire logic [sprm_pkg::PAD_COUNT-1:0] pad_in, // Subsystem pad buffer inputs
    output logic [sprm_pkg::PAD_COUNT-1:0] pad_out, // Subsystem pad buffer outputs
    output logic [sprm_pkg::PAD_COUNT-1:0] pad_oe, // Subsystem pad enables, high drives
    output logic [sprm_pkg::MUX_COUNT-1:0] pad_pull_up, // Pull-up per entry
    output logic [sprm_pkg::MUX_COUNT-1:0] pad_pull_down, // Pull-down per entry
    output logic [sprm_pkg::MUX_COUNT-1:0] pad_schmitt_trigger, // Schmitt per entry
    output logic [sprm_pkg::FAB_W-1:0] to_fabric_signal, // Subsystem to fabric
    input wire logic [sprm_pkg::FAB_W-1:0] from_fabric_signal, // Fabric to subsystem
    input wire logic [sprm_pkg::FAB_W-1:0] from_fabric_output_enable // Fabric enables
);

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration state

    sprm_pkg::sprm_top_st_t st_reg;
    sprm_pkg::sprm_top_st_t st_next;
    logic entry_ok;

    assign entry_ok = cfg_entry < sprm_pkg::ENTRY_W'(sprm_pkg::MUX_COUNT);

    always_comb
    begin
        st_next = st_reg;
        if (cfg_wr && entry_ok)
        begin
            st_next.cfg[cfg_entry] = cfg_wdata; // see RULE6
            st_next.loaded[cfg_entry] = 1'b1; // see RULE9
        end
        st_next.rdata = entry_ok ? st_reg.cfg[cfg_entry] : sprm_pkg::CFG_RESET;
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign cfg_rdata = st_reg.rdata;
    assign cfg_all_loaded = st_reg.loaded == sprm_pkg::ALL_LOADED;

    always_comb
    begin
        cfg_mux_num = '0;
        for (int i = 0; i < sprm_pkg::MUX_COUNT; i++)
        begin
            if (cfg_entry == sprm_pkg::ENTRY_W'(i))
            begin
                cfg_mux_num = sprm_pkg::MUX_NUM[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Primary and alternate side sources

    logic [sprm_pkg::MUX_COUNT-1:0] a_out;
    logic [sprm_pkg::MUX_COUNT-1:0] a_oe;
    logic [sprm_pkg::MUX_COUNT-1:0] b_out;
    logic [sprm_pkg::MUX_COUNT-1:0] b_oe;
    logic [sprm_pkg::MUX_COUNT-1:0] pad_i;
    logic [sprm_pkg::MUX_COUNT-1:0] a_in;
    logic [sprm_pkg::MUX_COUNT-1:0] b_in;
    logic [sprm_pkg::MUX_COUNT-1:0] p_out;
    logic [sprm_pkg::MUX_COUNT-1:0] p_oe;

    always_comb
    begin
        a_out = '0;
        a_oe = '0; // see RULE10
        b_out = '0;
        b_oe = '0;
        pad_i = '0;
        a_out[sprm_pkg::E_TX0] = uart0_txd; // see RULE4
        a_out[sprm_pkg::E_TX1] = uart1_txd; // see RULE1
        a_out[sprm_pkg::E_GPIO20_FAB] = gpio_out[sprm_pkg::GPIO20_BIT]; // see RULE5
        a_out[sprm_pkg::E_U0_MODEM] = uart0_rts; // see RULE7
        a_out[sprm_pkg::E_U0_MODEM + 1] = uart0_dtr; // see RULE8
        a_out[sprm_pkg::E_U1_MODEM] = uart1_rts; // see RULE8
        a_out[sprm_pkg::E_U1_MODEM + 1] = uart1_dtr; // see RULE8
        for (int m = 0; m < sprm_pkg::MODEM_OUT_LINES; m++)
        begin
            a_oe[sprm_pkg::E_U0_MODEM + m] = 1'b1; // see RULE10
            a_oe[sprm_pkg::E_U1_MODEM + m] = 1'b1; // see RULE10
        end
        for (int p = 0; p < sprm_pkg::PAD_COUNT; p++)
        begin
            b_out[p] = gpio_out[p];
            b_oe[p] = gpio_oe[p];
            pad_i[p] = pad_in[p];
        end
        for (int f = sprm_pkg::PAD_COUNT; f < sprm_pkg::MUX_COUNT; f++)
        begin
            b_out[f] = from_fabric_signal[sprm_pkg::FAB_IDX[f]]; // see RULE2
            b_oe[f] = from_fabric_output_enable[sprm_pkg::FAB_IDX[f]];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Multiplexer cells

    genvar g;
    generate
        for (g = 0; g < sprm_pkg::MUX_COUNT; g++)
        begin : g_mux
            sprm_mux_cell #(
                .LOOP(sprm_pkg::IS_LOOP[g])
            ) u_cell (
                .core_clk(core_clk),
                .rstn(rstn),
                .sel_b(st_reg.cfg[g].sel_b),
                .a_out(a_out[g]),
                .a_oe(a_oe[g]),
                .b_out(b_out[g]),
                .b_oe(b_oe[g]),
                .pad_in(pad_i[g]),
                .a_in(a_in[g]),
                .b_in(b_in[g]),
                .pad_out(p_out[g]),
                .pad_oe(p_oe[g])
            );
            assign pad_pull_up[g] = st_reg.cfg[g].pull_up; // see RULE11
            assign pad_pull_down[g] = st_reg.cfg[g].pull_down; // see RULE11
            assign pad_schmitt_trigger[g] = st_reg.cfg[g].schmitt; // see RULE11
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Port side results

    always_comb
    begin
        to_fabric_signal = '0;
        for (int f = sprm_pkg::PAD_COUNT; f < sprm_pkg::MUX_COUNT; f++)
        begin
            to_fabric_signal[sprm_pkg::FAB_IDX[f]] = b_in[f]; // see RULE2
        end
    end

    assign pad_out = p_out[sprm_pkg::PAD_COUNT-1:0];
    assign pad_oe = p_oe[sprm_pkg::PAD_COUNT-1:0];
    assign uart0_rxd = a_in[sprm_pkg::E_RX0];
    assign uart1_rxd = a_in[sprm_pkg::E_RX1];

    always_comb
    begin
        uart0_modem_in = '0;
        uart1_modem_in = '0;
        // CTS sits in the top bit of the struct but first in entry order
        for (int m = 0; m < sprm_pkg::MODEM_LINES - sprm_pkg::MODEM_OUT_LINES; m++)
        begin
            uart0_modem_in[sprm_pkg::MODEM_LINES - sprm_pkg::MODEM_OUT_LINES - 1 - m] =
                a_in[sprm_pkg::E_U0_MODEM + sprm_pkg::MODEM_OUT_LINES + m]; // see RULE8
            uart1_modem_in[sprm_pkg::MODEM_LINES - sprm_pkg::MODEM_OUT_LINES - 1 - m] =
                a_in[sprm_pkg::E_U1_MODEM + sprm_pkg::MODEM_OUT_LINES + m]; // see RULE8
        end
    end

    always_comb
    begin
        gpio_in = b_in[sprm_pkg::PAD_COUNT-1:0];
        // GPIO 20 input can arrive from its pad or from the fabric
        gpio_in[sprm_pkg::GPIO20_BIT] = b_in[sprm_pkg::GPIO20_BIT]
            | a_in[sprm_pkg::E_GPIO20_FAB]; // see RULE5
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    tx0_pad_route_a: assert property ( // see RULE4
        !st_reg.cfg[sprm_pkg::E_TX0].sel_b && $stable(st_reg.cfg[sprm_pkg::E_TX0])
        |=> pad_out[0] == $past(uart0_txd) && !pad_oe[0])
        else $error("pad 0 does not follow port 0 transmit");

    gpio_pad_route_a: assert property ( // see RULE1
        st_reg.cfg[sprm_pkg::E_TX1].sel_b && $stable(st_reg.cfg[sprm_pkg::E_TX1])
        |=> pad_out[2] == $past(gpio_out[2]) && pad_oe[2] == $past(gpio_oe[2]))
        else $error("pad 2 does not follow GPIO 28");

    rx_one_owner_a: assert property ( // see RULE3
        !(uart0_rxd && gpio_in[1]) && !(uart1_rxd && gpio_in[3]))
        else $error("receive pad seen by two functions");

    rx_sync_path_a: assert property ( // see RULE3
        (!st_reg.cfg[sprm_pkg::E_RX0].sel_b)[*4] |-> uart0_rxd == $past(pad_in[1], 3))
        else $error("port 0 receive not three cycles after pad");

    rts_to_fabric_a: assert property ( // see RULE7
        st_reg.cfg[sprm_pkg::E_U0_MODEM].sel_b ##1 st_reg.cfg[sprm_pkg::E_U0_MODEM].sel_b
        |-> to_fabric_signal[48] == $past(uart0_rts))
        else $error("RTS 0 not on to-fabric signal 48");

    cts_from_fabric_a: assert property ( // see RULE8
        (st_reg.cfg[sprm_pkg::E_U1_MODEM + 2].sel_b)[*4]
        |-> uart1_modem_in.cts == $past(from_fabric_signal[63], 3))
        else $error("CTS 1 not from fabric signal 63");

    modem_unrouted_a: assert property ( // see RULE2
        (!st_reg.cfg[sprm_pkg::E_U0_MODEM + 1].sel_b)[*2] |-> !to_fabric_signal[49])
        else $error("DTR 0 reaches fabric while unrouted");

    gpio20_fabric_a: assert property ( // see RULE5
        (st_reg.cfg[sprm_pkg::E_GPIO20_FAB].sel_b)[*2]
        |-> to_fabric_signal[29] == $past(gpio_out[0]))
        else $error("GPIO 20 not on to-fabric signal 29");

    cfg_write_a: assert property ( // see RULE11
        cfg_wr && cfg_entry == 5'h08 |=> pad_pull_up[8] == $past(cfg_wdata.pull_up)
        && pad_schmitt_trigger[8] == $past(cfg_wdata.schmitt))
        else $error("pad settings not taken from write");

    no_pad_loop_a: assert property ( // see RULE10
        !st_reg.cfg[sprm_pkg::E_RX0].sel_b |=> !pad_out[1] && !pad_oe[1])
        else $error("receive pad driven from the primary side");

    fabric_route_c: cover property (
        st_reg.cfg[sprm_pkg::E_U0_MODEM].sel_b && to_fabric_signal[48]);
    gpio_pad_c: cover property (st_reg.cfg[sprm_pkg::E_TX0].sel_b && pad_oe[0]);
    all_loaded_c: cover property (cfg_all_loaded);

endmodule : sprm_routing

`default_nettype wire

// ==== logic/sprm_pkg.sv ====
// Purpose: Shared types and constants for the serial port pin routing multiplexers
// Assumes: One clock, static configuration loaded by boot code
// Notes: Entry numbers index the seventeen routing multiplexers of the block
package sprm_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int MUX_COUNT = 17;
    localparam int FAB_W = 67;
    localparam int PAD_COUNT = 4;
    localparam int ENTRY_W = 5;
    localparam int MUXNUM_W = 7;

    ////////////////////////////////////////////////////////////////////////////////
    // Entry positions
    localparam int E_TX0 = 0;
    localparam int E_RX0 = 1;
    localparam int E_TX1 = 2;
    localparam int E_RX1 = 3;
    localparam int E_GPIO20_FAB = 4;
    localparam int E_U0_MODEM = 5;
    localparam int E_U1_MODEM = 11;
    localparam int MODEM_LINES = 6;
    localparam int MODEM_OUT_LINES = 2;
    localparam int GPIO20_BIT = 0;

    // Routing multiplexer number per entry
    localparam logic [MUXNUM_W-1:0] MUX_NUM [MUX_COUNT] = '{
        7'h04, 7'h05, 7'h0C, 7'h0D, 7'h2D,
        7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45,
        7'h4D, 7'h4E, 7'h4F, 7'h50, 7'h51, 7'h52};

    // Fabric interface signal index per entry, zero for pad entries
    localparam int FAB_IDX [MUX_COUNT] = '{
        0, 0, 0, 0, 29,
        48, 49, 50, 51, 52, 53,
        61, 62, 63, 64, 65, 66};

    // Entries that loop the primary side to the fabric interface
    localparam logic [MUX_COUNT-1:0] IS_LOOP = 17'h1_FFF0;

    ////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic sel_b;
        logic pull_up;
        logic pull_down;
        logic schmitt;
    } sprm_cfg_t;

    typedef struct packed {
        logic cts;
        logic dsr;
        logic ri;
        logic dcd;
    } sprm_modem_in_t;

    typedef struct packed {
        logic ext_s1;
        logic ext_s2;
        logic a_in;
        logic b_in;
        logic pad_out;
        logic pad_oe;
    } sprm_cell_st_t;

    typedef struct packed {
        sprm_cfg_t [MUX_COUNT-1:0] cfg;
        logic [MUX_COUNT-1:0] loaded;
        sprm_cfg_t rdata;
    } sprm_top_st_t;

    localparam sprm_cfg_t CFG_RESET = 4'h0;
    localparam sprm_cell_st_t CELL_RESET = 6'h00;
    localparam logic [MUX_COUNT-1:0] ALL_LOADED = 17'h1_FFFF;

endpackage : sprm_pkg

// ==== logic/sprm_mux_cell.sv ====
// Purpose: One routing multiplexer, pad sharing or loop to the fabric interface
// Assumes: The outside input is asynchronous and is synchronised here
// Notes: All outputs come from flip-flops
`timescale 1ns/1ps
`default_nettype none

module sprm_mux_cell #(
    parameter bit LOOP = 1'b0
) (
    input wire logic core_clk, // System clock
    input wire logic rstn, // Async reset, active low
    input wire logic sel_b, // Alternate side selected
    input wire logic a_out, // Primary side output
    input wire logic a_oe, // Primary side output enable
    input wire logic b_out, // Alternate side output, from fabric in loop mode
    input wire logic b_oe, // Alternate side output enable
    input wire logic pad_in, // Pad buffer input
    output logic a_in, // Primary side input
    output logic b_in, // Alternate side input, to fabric in loop mode
    output logic pad_out, // Pad buffer output
    output logic pad_oe // Pad buffer output enable
);

    sprm_pkg::sprm_cell_st_t st_reg;
    sprm_pkg::sprm_cell_st_t st_next;

    always_comb
    begin
        st_next = st_reg;
        st_next.ext_s1 = LOOP ? b_out : pad_in;
        st_next.ext_s2 = st_reg.ext_s1;
        if (LOOP)
        begin
            // Primary output passes to alternate input, fabric back to primary
            st_next.b_in = sel_b & a_out; // see RULE7
            st_next.a_in = sel_b & st_reg.ext_s2; // see RULE8
            st_next.pad_out = 1'b0;
            st_next.pad_oe = 1'b0;
        end
        else
        begin
            // Only one side owns the shared pad at a time
            st_next.a_in = ~sel_b & st_reg.ext_s2; // see RULE3
            st_next.b_in = sel_b & st_reg.ext_s2; // see RULE3
            st_next.pad_out = sel_b ? b_out : a_out; // see RULE1
            st_next.pad_oe = sel_b ? b_oe : a_oe; // see RULE1
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg <= sprm_pkg::CELL_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign a_in = st_reg.a_in;
    assign b_in = st_reg.b_in;
    assign pad_out = st_reg.pad_out;
    assign pad_oe = st_reg.pad_oe;

endmodule : sprm_mux_cell

`default_nettype wire

// ==== test/sprm_far_model.sv ====
// Purpose: Far side of the routing block: pad buffers and fabric logic
// Assumes: Bench sets the outside pad level and the fabric drive values
// Notes: An undriven pad with no pull shows a pattern that flips every cycle
`timescale 1ns/1ps
`default_nettype none

module sprm_far_model (
    input wire logic core_clk, // System clock
    input wire logic [sprm_pkg::PAD_COUNT-1:0] pad_out, // Subsystem pad outputs
    input wire logic [sprm_pkg::PAD_COUNT-1:0] pad_oe, // Subsystem pad enables
    input wire logic [sprm_pkg::PAD_COUNT-1:0] pad_pull_up, // Pull-ups of pad entries
    input wire logic [sprm_pkg::PAD_COUNT-1:0] pad_pull_down, // Pull-downs of pad entries
    input wire logic [sprm_pkg::PAD_COUNT-1:0] ext_en, // Outside device drives pad
    input wire logic [sprm_pkg::PAD_COUNT-1:0] ext_val, // Outside device level
    input wire logic [sprm_pkg::FAB_W-1:0] fab_val, // Fabric logic drive values
    input wire logic [sprm_pkg::FAB_W-1:0] fab_oe, // Fabric logic enables
    output logic [sprm_pkg::PAD_COUNT-1:0] pad_in, // Pad level seen by subsystem
    output logic [sprm_pkg::FAB_W-1:0] from_fabric_signal, // Fabric to subsystem
    output logic [sprm_pkg::FAB_W-1:0] from_fabric_output_enable // Fabric enables
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pad wire level
    logic [sprm_pkg::PAD_COUNT-1:0] flip_reg = 4'h5;

    always @(posedge core_clk)
        flip_reg <= ~flip_reg;

    // Floating pad never holds its last value
    always_comb
        for (int i = 0; i < sprm_pkg::PAD_COUNT; i++)
            pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                pad_pull_up[i] ? 1'h1 : pad_pull_down[i] ? 1'h0 : flip_reg[i];

    ////////////////////////////////////////////////////////////////////////////////
    // Fabric logic
    always_comb
    begin
        from_fabric_signal = fab_val;
        from_fabric_output_enable = fab_oe;
    end

endmodule : sprm_far_model

`default_nettype wire

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench for the serial port pin routing multiplexers
// Assumes: Boot-style load of every entry through the configuration ports
// Notes: Random values from a fixed seed; inputs held steady before each check
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic core_clk, rstn, cfg_wr;
    logic [4:0] cfg_entry;
    sprm_pkg::sprm_cfg_t cfg_wdata, cfg_rdata;
    sprm_pkg::sprm_cfg_t sh [18];
    sprm_pkg::sprm_modem_in_t m0, m1;
    logic [6:0] mux_num;
    logic all_loaded, tx0, rx0, tx1, rx1, rts0, dtr0, rts1, dtr1;
    logic [3:0] gpo, gpoe, gpi, pin, pout, poe, ext_en, ext_val;
    logic [16:0] pu, pd, st;
    logic [66:0] to_fab, from_fab, from_oe, fab_val, fab_oe;
    int n_errors, n_checks, seed;
    int mux_tbl [18] = '{4, 5, 12, 13, 45, 64, 65, 66, 67, 68, 69, 77, 78, 79, 80, 81, 82, 0};

    sprm_routing dut_u (
        .core_clk(core_clk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_entry(cfg_entry),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_mux_num(mux_num),
        .cfg_all_loaded(all_loaded), .uart0_txd(tx0), .uart0_rxd(rx0), .uart1_txd(tx1),
        .uart1_rxd(rx1), .uart0_rts(rts0), .uart0_dtr(dtr0), .uart0_modem_in(m0),
        .uart1_rts(rts1), .uart1_dtr(dtr1), .uart1_modem_in(m1), .gpio_out(gpo),
        .gpio_oe(gpoe), .gpio_in(gpi), .pad_in(pin), .pad_out(pout), .pad_oe(poe),
        .pad_pull_up(pu), .pad_pull_down(pd), .pad_schmitt_trigger(st),
        .to_fabric_signal(to_fab), .from_fabric_signal(from_fab),
        .from_fabric_output_enable(from_oe));

    sprm_far_model far_u (
        .core_clk(core_clk), .pad_out(pout), .pad_oe(poe), .pad_pull_up(pu[3:0]),
        .pad_pull_down(pd[3:0]), .ext_en(ext_en), .ext_val(ext_val), .fab_val(fab_val),
        .fab_oe(fab_oe), .pad_in(pin), .from_fabric_signal(from_fab),
        .from_fabric_output_enable(from_oe));

    initial
    begin
        core_clk = 1'h0;
        forever #10 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Tasks and expectations
    task automatic chk(input string what, input logic [66:0] exp, input logic [66:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_cfg(input int e, input sprm_pkg::sprm_cfg_t d);
        @(posedge core_clk);
        cfg_wr <= 1'h1;
        cfg_entry <= 5'(e);
        cfg_wdata <= d;
        if (e < 17)
            sh[e] = d;
    endtask : wr_cfg

    task automatic wr_end();
        @(posedge core_clk);
        cfg_wr <= 1'h0;
    endtask : wr_end

    task automatic settle();
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
    endtask : settle

    task automatic finish_test();
        $display("Checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    // Expected {pad_out, pad_oe, gpio_in, rxd} of one shared pad
    function automatic logic [3:0] pad_exp(int e, bit s, logic t, logic g, logic o, logic v);
        logic lvl;
        lvl = (s && o) ? g : v;
        if (s)
            return {g, o, lvl, 1'h0};
        return {(e % 2 == 0) ? t : 1'h0, 1'h0, 1'h0, (e % 2 == 1) ? lvl : 1'h0};
    endfunction : pad_exp

    function automatic logic [66:0] fab_exp(logic [11:0] s, logic [3:0] r);
        logic [66:0] f;
        f = '0;
        f[48] = s[0] & r[3];
        f[49] = s[1] & r[2];
        f[61] = s[6] & r[1];
        f[62] = s[7] & r[0];
        return f;
    endfunction : fab_exp

    // Struct puts cts in the top bit, fabric index order puts cts at the lowest index
    function automatic logic [3:0] mdm_exp(logic [3:0] s, logic [3:0] f);
        return {s[0] & f[0], s[1] & f[1], s[2] & f[2], s[3] & f[3]};
    endfunction : mdm_exp

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic [3:0] r;
        logic [11:0] sel;
        seed = $urandom(33);
        rstn = 1'h0;
        {cfg_wr, cfg_entry, cfg_wdata, tx0, tx1, rts0, dtr0, rts1, dtr1} = '0;
        {gpo, gpoe, ext_en, ext_val, fab_val, fab_oe} = '0;
        sh[17] = '0;
        repeat (4) @(posedge core_clk);
        rstn <= 1'h1;
        @(negedge core_clk);
        chk("reset pad enable", 67'h0, 67'(poe));
        chk("reset fabric", 67'h0, to_fab);
        // Boot load of every entry, last entry held back
        for (int e = 0; e < 17; e++)
        begin
            if (e == 16)
            begin
                wr_end();
                @(negedge core_clk);
                chk("partly loaded", 67'h0, 67'(all_loaded));
            end
            wr_cfg(e, 4'($urandom));
        end
        wr_cfg(17, 4'hF);
        wr_end();
        @(negedge core_clk);
        chk("all loaded", 67'h1, 67'(all_loaded));
        for (int e = 0; e < 17; e++)
            chk("pulls", {sh[e].pull_up, sh[e].pull_down, sh[e].schmitt}, {pu[e], pd[e], st[e]});
        for (int e = 0; e < 18; e++)
        begin
            @(posedge core_clk);
            cfg_entry <= 5'(e);
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            chk("readback", 67'(sh[e]), 67'(cfg_rdata));
            chk("mux number", 67'(mux_tbl[e]), 67'(mux_num));
        end
        // Shared pads on both sides
        for (int k = 0; k < 16; k++)
        begin
            int e;
            bit s;
            logic [3:0] g, o, v, x;
            logic t;
            e = k % 4;
            s = k[2];
            g = 4'($urandom);
            o = (k > 11) ? 4'hF : 4'($urandom);
            v = 4'($urandom);
            t = 1'($urandom);
            wr_cfg(e, {s, 3'($urandom)});
            wr_cfg(4, 4'h0);
            wr_end();
            @(posedge core_clk);
            gpo <= g;
            gpoe <= o;
            ext_val <= v;
            ext_en <= 4'hF;
            tx0 <= t;
            tx1 <= t;
            settle();
            x = pad_exp(e, s, t, g[e], o[e], v[e]);
            chk("pad out", 67'(x[3]), 67'(pout[e]));
            chk("pad enable", 67'(x[2]), 67'(poe[e]));
            chk("gpio in", 67'(x[1]), 67'(gpi[e]));
            chk("rx line", 67'(x[0]), 67'((e == 1) ? rx0 : (e == 3) ? rx1 : 1'h0));
        end
        // Modem lines over the fabric interface
        for (int k = 0; k < 6; k++)
        begin
            sel = (k == 0) ? 12'hFFF : 12'($urandom);
            for (int i = 0; i < 12; i++)
                wr_cfg(i + 5, {sel[i], 3'($urandom)});
            wr_end();
            @(posedge core_clk);
            r = 4'($urandom);
            fab_val <= 67'({$urandom, $urandom, $urandom});
            fab_oe <= 67'({$urandom, $urandom, $urandom});
            {rts0, dtr0, rts1, dtr1} <= r;
            settle();
            chk("to fabric", fab_exp(sel, r), to_fab);
            chk("port 0 modem in", 67'(mdm_exp(sel[5:2], fab_val[53:50])), 67'(m0));
            chk("port 1 modem in", 67'(mdm_exp(sel[11:8], fab_val[66:63])), 67'(m1));
        end
        // GPIO 20 routed to the fabric interface
        wr_cfg(0, 4'h0);
        wr_cfg(4, 4'h8);
        wr_end();
        for (int k = 0; k < 4; k++)
        begin
            @(posedge core_clk);
            r = 4'($urandom);
            gpo <= r;
            fab_val[29] <= r[1];
            settle();
            chk("gpio 20 to fabric", 67'(r[0]), 67'(to_fab[29]));
            chk("gpio 20 from fabric", 67'(r[1]), 67'(gpi[0]));
        end
        // Reset in mid-run clears the configuration
        @(posedge core_clk);
        rstn <= 1'h0;
        @(negedge core_clk);
        chk("second reset loaded", 67'h0, 67'(all_loaded));
        chk("second reset pulls", 67'h0, 67'(pu));
        finish_test();
    end

    initial
    begin
        repeat (5000) @(posedge core_clk);
        n_errors++;
        $display("ERROR watchdog expected done seen timeout");
        finish_test();
    end

endmodule : tb_top

`default_nettype wire
